// ---- hdl/adc_seq_pkg.sv ----
// Function
// R01 - One 8-bit converter, all sequencing timed from serial clock edges; launch, frame pacing and publish here run on chip-enable falls.
// R02 - Eight-way input multiplexer routes exactly one source to the converter.
// R03 - Channel field is normal-frame bits 4 down to 2, lsb at bit 2.
// R04 - Field 00X converts general input 0 or 1 once.
// R05 - Field 011 converts A, B or a complement chosen by phase bits.
// R06 - Field 1XX converts a pair chosen by the low two field bits.
// R07 - Pair members convert in fixed order, first then second, with sample-hold.
// R08 - Phase bits captured on serial clock rise while enabled, returned in bits 3:2.
// R09 - Start bit 1 launches conversion on that frame's channel field.
// R10 - Start arriving during a running conversion is discarded entirely.
// R11 - Conversion finishes in the frame before its result is returned.
// R12 - Start in the result frame launches next conversion at once.
// R13 - Single conversion paced to four frames, or eight when config bit 3 set.
// R14 - Host requests no diagnostic word while a conversion runs.
// R15 - Position is quadrature count above the 8-bit converter result.
// R16 - Amplifier gain accepted and applied any time, no reset or idle needed.
// R17 - Monitor terminals either carry amplifier outputs or act as general inputs.
// R18 - First or second done bit raised for exactly one frame per result.
// R19 - Output frame bits 6:4 report which input the result belongs to.
// R20 - Input frame with bit 0 clear is a normal frame.
// R21 - Quadrature count steps by one per valid phase change, leading phase sets direction.
package adc_seq_pkg;

    // Serial frame layout.
    localparam int FRAME_BITS = 16;
    localparam int CFG_BIT = 0;
    localparam int START_BIT = 1;
    localparam int FIELD_LSB = 2;
    localparam int FIELD_MSB = 4;
    localparam int CFG_SLOW_BIT = 3;

    // Converter sizing and timing in serial clock periods and frames.
    localparam int RES_BITS = 8;
    localparam logic [3:0] SAMPLE_SCLKS = 4'hf;
    localparam logic [3:0] PACE_FAST_FRAMES = 4'h4;
    localparam logic [3:0] PACE_SLOW_FRAMES = 4'h8;
    localparam int QCNT_BITS = 16;
    localparam int GAIN_BITS = 4;

    // Source codes, equal to the reported channel code {r2,r1,r0}.
    localparam logic [2:0] SRC_GEN0 = 3'h0;
    localparam logic [2:0] SRC_GEN1 = 3'h1;
    localparam logic [2:0] SRC_DIR2 = 3'h2;
    localparam logic [2:0] SRC_DIR3 = 3'h3;
    localparam logic [2:0] SRC_ENC_A = 3'h4;
    localparam logic [2:0] SRC_ENC_B = 3'h5;
    localparam logic [2:0] SRC_ENC_AN = 3'h6;
    localparam logic [2:0] SRC_ENC_BN = 3'h7;

    // Channel field values.
    localparam logic [2:0] FIELD_AUTO = 3'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_WAIT_PUB = 2'b11
    } seq_state_t;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,       // System clock.
    input wire logic sys_rst_i,       // Asynchronous reset, active high.
    input wire logic [W-1:0] async_i, // Pins from outside the clock domain.
    output logic [W-1:0] sync_o       // Second-stage outputs.
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_reg_t;

    sync_reg_t st_q;
    sync_reg_t st_d;

    // The first stage feeds only the second stage to let metastability settle.
    always_comb begin
        st_d.meta = async_i;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stable;
endmodule // pin_sync

// ---- hdl/quad_counter.sv ----
`timescale 1ns/1ps
module quad_counter (
    input wire logic ref_clk_i,        // System clock.
    input wire logic sys_rst_i,        // Asynchronous reset, active high.
    input wire logic phase_a_i,        // Synchronised phase A.
    input wire logic phase_b_i,        // Synchronised phase B.
    output logic [adc_seq_pkg::QCNT_BITS-1:0] count_o // Quadrature count.
);
    typedef struct packed {
        logic [1:0] prev;
        logic [adc_seq_pkg::QCNT_BITS-1:0] count;
    } quad_reg_t;

    quad_reg_t st_q;
    quad_reg_t st_d;
    logic [1:0] cur;
    logic [1:0] diff;
    logic up;

    // A double change is a skipped state and is dropped rather than guessed.
    always_comb begin
        cur = {phase_a_i, phase_b_i};
        diff = cur ^ st_q.prev;
        up = phase_a_i ^ st_q.prev[0];
        st_d = st_q;
        st_d.prev = cur;
        if (diff == 2'h1 || diff == 2'h2) begin // [R21]
            st_d.count = up ? st_q.count + 1'b1 : st_q.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.count;

    a_quad_single_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R21]
        ($countones(cur ^ st_q.prev) == 1) |=>
        (st_q.count == $past(st_q.count) + 1'b1 || st_q.count == $past(st_q.count) - 1'b1))
        else $error("Quadrature count did not step by one.");
    a_quad_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R21]
        ($countones(cur ^ st_q.prev) != 1) |=> $stable(st_q.count))
        else $error("Quadrature count moved without a valid step.");
endmodule // quad_counter

// ---- hdl/encoder_adc_sequencer.sv ----
`timescale 1ns/1ps
module encoder_adc_sequencer (
    input wire logic ref_clk_i,                  // System clock, 250 MHz.
    input wire logic sys_rst_i,                  // Asynchronous reset, active high.
    input wire logic sclk_i,                     // Serial clock pin.
    input wire logic ce_i,                       // Chip enable pin, active high.
    input wire logic mosi_i,                     // Serial input data, msb first.
    input wire logic comp_i,                     // Comparator: held input above trial code.
    input wire logic enc_phase_a_bit_i,          // Filtered digital phase A pin.
    input wire logic enc_phase_b_bit_i,          // Filtered digital phase B pin.
    input wire logic [adc_seq_pkg::GAIN_BITS-1:0] gain_set_i, // Gain from serial logic.
    input wire logic amp_route_i,                // Route amplifiers to monitor terminals.
    output logic [2:0] mux_sel_o,                // Selected converter source.
    output logic sample_hold_o,                  // High while the hold capacitor tracks.
    output logic [adc_seq_pkg::RES_BITS-1:0] dac_code_o, // Trial code to the comparator.
    output logic busy_o,                         // Conversion in progress.
    output logic [adc_seq_pkg::RES_BITS-1:0] result_o, // Returned conversion result.
    output logic first_done_o,                   // First result done, one frame.
    output logic second_done_o,                  // Second result done, one frame.
    output logic [2:0] reported_channel_code_o,  // Source of result_o, frame bits 6:4.
    output logic [1:0] enc_phase_o,              // Captured phases, frame bits 3:2.
    output logic [adc_seq_pkg::QCNT_BITS+adc_seq_pkg::RES_BITS-1:0] position_o, // Encoder position.
    output logic [adc_seq_pkg::GAIN_BITS-1:0] gain_o, // Applied amplifier gain.
    output logic amp_monitor_drive_o,            // Amplifiers drive monitor terminals.
    output logic cfg_slow_o                      // Slow pacing from config bit 3.
);
    typedef struct packed {
        adc_seq_pkg::seq_state_t state;
        logic [adc_seq_pkg::FRAME_BITS-1:0] shreg;
        logic [4:0] bitcnt;
        logic sclk_d;
        logic ce_d;
        logic slow;
        logic [2:0] field;
        logic second;
        logic [3:0] sclks;
        logic [2:0] sar_idx;
        logic [adc_seq_pkg::RES_BITS-1:0] sar;
        logic [3:0] frames;
        logic [2:0] src;
        logic [adc_seq_pkg::RES_BITS-1:0] result;
        logic [2:0] code;
        logic done1;
        logic done2;
        logic [1:0] phase;
        logic [adc_seq_pkg::GAIN_BITS-1:0] gain;
        logic mon;
    } seq_reg_t;

    seq_reg_t st_q;
    seq_reg_t st_d;
    logic [5:0] pins_s;
    logic mosi_s;
    logic sclk_s;
    logic ce_s;
    logic comp_s;
    logic pha_s;
    logic phb_s;
    logic sclk_rise;
    logic frame_end;
    logic normal_frame;
    logic start_req;
    logic [2:0] rx_field;
    logic publish;
    logic [adc_seq_pkg::QCNT_BITS-1:0] qcount;

    // Pacing limit in frames from the slow configuration bit.
    function automatic logic [3:0] pace_limit(input logic slow);
        pace_limit = slow ? adc_seq_pkg::PACE_SLOW_FRAMES : adc_seq_pkg::PACE_FAST_FRAMES; // [R13]
    endfunction

    // First source of a request; the auto-select case follows the phase bits.
    function automatic logic [2:0] first_src(input logic [2:0] field, input logic [1:0] ph);
        logic [2:0] s;
        s = adc_seq_pkg::SRC_GEN0;
        if (field[2]) begin // [R06]
            unique case (field[1:0])
                2'b00: s = adc_seq_pkg::SRC_ENC_A;
                2'b01: s = adc_seq_pkg::SRC_ENC_A;
                2'b10: s = adc_seq_pkg::SRC_ENC_B;
                2'b11: s = adc_seq_pkg::SRC_DIR2;
            endcase
        end else if (field == adc_seq_pkg::FIELD_AUTO) begin // [R05]
            // The phases are held as {B,A}, so A set with B clear reads 01 here.
            unique case (ph)
                2'b01: s = adc_seq_pkg::SRC_ENC_A;
                2'b10: s = adc_seq_pkg::SRC_ENC_AN;
                2'b11: s = adc_seq_pkg::SRC_ENC_B;
                2'b00: s = adc_seq_pkg::SRC_ENC_BN;
            endcase
        end else begin // [R04]
            s = field[0] ? adc_seq_pkg::SRC_GEN1 : adc_seq_pkg::SRC_GEN0;
        end
        first_src = s;
    endfunction

    // Second member of a pair, in fixed order after the first.
    function automatic logic [2:0] second_src(input logic [1:0] sel);
        logic [2:0] s;
        s = adc_seq_pkg::SRC_ENC_B;
        unique case (sel) // [R07]
            2'b00: s = adc_seq_pkg::SRC_ENC_B;
            2'b01: s = adc_seq_pkg::SRC_ENC_AN;
            2'b10: s = adc_seq_pkg::SRC_ENC_BN;
            2'b11: s = adc_seq_pkg::SRC_DIR3;
        endcase
        second_src = s;
    endfunction

    // Start a fresh sample on a source; the frame count restarts for pacing.
    function automatic seq_reg_t launch(input seq_reg_t s, input logic [2:0] src);
        seq_reg_t n;
        n = s;
        n.state = adc_seq_pkg::ST_SAMPLE;
        n.src = src;
        n.sclks = '0;
        n.frames = '0;
        n.sar = '0;
        n.sar_idx = 3'h7;
        launch = n;
    endfunction

    // All pins come from outside the clock domain; data and clock share the delay.
    pin_sync #(
        .W(6)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({mosi_i, sclk_i, ce_i, comp_i, enc_phase_a_bit_i, enc_phase_b_bit_i}),
        .sync_o(pins_s)
    );

    assign mosi_s = pins_s[5];
    assign sclk_s = pins_s[4];
    assign ce_s = pins_s[3];
    assign comp_s = pins_s[2];
    assign pha_s = pins_s[1];
    assign phb_s = pins_s[0];

    quad_counter u_quad_counter (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .phase_a_i(pha_s),
        .phase_b_i(phb_s),
        .count_o(qcount)
    );

    // Frame events; only complete 16-bit normal frames carry a start.
    assign sclk_rise = sclk_s & ~st_q.sclk_d;
    assign frame_end = st_q.ce_d & ~ce_s;
    assign normal_frame = (st_q.bitcnt == 5'(adc_seq_pkg::FRAME_BITS)) &&
                          !st_q.shreg[adc_seq_pkg::CFG_BIT]; // [R20]
    assign start_req = normal_frame && st_q.shreg[adc_seq_pkg::START_BIT]; // [R09]
    assign rx_field = st_q.shreg[adc_seq_pkg::FIELD_MSB:adc_seq_pkg::FIELD_LSB]; // [R03]
    assign publish = frame_end && (st_q.state == adc_seq_pkg::ST_WAIT_PUB) &&
                     (st_q.frames >= pace_limit(st_q.slow) - 4'h1); // [R11] [R13]

    // Next-state logic for the frame receiver, sequencer and converter.
    always_comb begin
        st_d = st_q;
        st_d.sclk_d = sclk_s;
        st_d.ce_d = ce_s;
        st_d.gain = gain_set_i; // [R16]
        st_d.mon = amp_route_i; // [R17]

        // Serial shift and phase capture while the chip is enabled.
        if (sclk_rise && ce_s) begin
            st_d.shreg = {st_q.shreg[adc_seq_pkg::FRAME_BITS-2:0], mosi_s};
            if (st_q.bitcnt != 5'h1F) begin
                st_d.bitcnt = st_q.bitcnt + 5'h01;
            end
            st_d.phase = {phb_s, pha_s}; // [R08]
        end
        if (!ce_s) begin
            st_d.bitcnt = '0;
        end

        // Config frames update the pacing bit.
        if (frame_end && st_q.bitcnt == 5'(adc_seq_pkg::FRAME_BITS) &&
            st_q.shreg[adc_seq_pkg::CFG_BIT]) begin
            st_d.slow = st_q.shreg[adc_seq_pkg::CFG_SLOW_BIT]; // [R13]
        end

        // Done bits last from the publishing frame end to the next one.
        if (frame_end) begin // [R18]
            st_d.done1 = 1'b0;
            st_d.done2 = 1'b0;
            if (st_q.state != adc_seq_pkg::ST_IDLE) begin
                st_d.frames = st_q.frames + 4'h1;
            end
        end

        unique case (st_q.state)
            adc_seq_pkg::ST_IDLE: begin
                if (frame_end && start_req) begin // [R09]
                    st_d = launch(st_d, first_src(rx_field, st_q.phase));
                    st_d.field = rx_field;
                    st_d.second = 1'b0;
                end
            end
            adc_seq_pkg::ST_SAMPLE: begin
                // The hold capacitor tracks for a fixed number of serial clocks.
                if (sclk_rise) begin // [R01]
                    st_d.sclks = st_q.sclks + 4'h1;
                    if (st_q.sclks == adc_seq_pkg::SAMPLE_SCLKS - 4'h1) begin
                        st_d.state = adc_seq_pkg::ST_CONVERT;
                        st_d.sar = 8'h80;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                // One successive-approximation bit per serial clock rise.
                if (sclk_rise) begin // [R01]
                    if (!comp_s) begin
                        st_d.sar[st_q.sar_idx] = 1'b0;
                    end
                    if (st_q.sar_idx == 3'h0) begin
                        st_d.state = adc_seq_pkg::ST_WAIT_PUB;
                    end else begin
                        st_d.sar_idx = st_q.sar_idx - 3'h1;
                        st_d.sar[st_q.sar_idx - 3'h1] = 1'b1;
                    end
                end
            end
            adc_seq_pkg::ST_WAIT_PUB: begin
                if (publish) begin
                    st_d.result = st_q.sar;
                    st_d.code = st_q.src; // [R19]
                    st_d.done1 = !st_q.second; // [R18]
                    st_d.done2 = st_q.second;
                    st_d.state = adc_seq_pkg::ST_IDLE;
                    if (st_q.field[2] && !st_q.second) begin // [R07]
                        st_d = launch(st_d, second_src(st_q.field[1:0]));
                        st_d.second = 1'b1;
                    end else if (start_req) begin // [R12]
                        st_d = launch(st_d, first_src(rx_field, st_q.phase));
                        st_d.field = rx_field;
                        st_d.second = 1'b0;
                    end
                end
            end
        endcase
        // Any start seen outside idle or the publishing frame is dropped. [R10]
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs all come from registers: the state register, and u_quad_counter for the count in position_o.
    assign mux_sel_o = st_q.src; // [R02]
    assign sample_hold_o = (st_q.state == adc_seq_pkg::ST_SAMPLE);
    assign dac_code_o = st_q.sar;
    assign busy_o = (st_q.state != adc_seq_pkg::ST_IDLE);
    assign result_o = st_q.result;
    assign first_done_o = st_q.done1;
    assign second_done_o = st_q.done2;
    assign reported_channel_code_o = st_q.code;
    assign enc_phase_o = st_q.phase;
    assign position_o = {qcount, st_q.result}; // [R15]
    assign gain_o = st_q.gain;
    assign amp_monitor_drive_o = st_q.mon;
    assign cfg_slow_o = st_q.slow;

    a_done_one_frame: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R18]
        (first_done_o && frame_end && !publish) |=> !first_done_o)
        else $error("First done bit held past one frame.");
    a_done_exclusive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R18]
        !(first_done_o && second_done_o))
        else $error("Both done bits high together.");
    a_single_select: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R04]
        (frame_end && !busy_o && start_req && rx_field[2:1] == 2'b00) |=>
        (busy_o && mux_sel_o == {2'b00, $past(rx_field[0])}))
        else $error("Single conversion selected the wrong input.");
    a_auto_select: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R05]
        (frame_end && !busy_o && start_req && rx_field == 3'h3 && enc_phase_o == 2'b01) |=>
        (mux_sel_o == adc_seq_pkg::SRC_ENC_A))
        else $error("Auto-select did not pick phase A signal.");
    a_pair_order: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R07]
        (publish && st_q.field == 3'h4 && !st_q.second) |=>
        (mux_sel_o == adc_seq_pkg::SRC_ENC_B && first_done_o && sample_hold_o))
        else $error("Pair second member not launched after the first.");
    a_busy_ignore: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        (frame_end && busy_o && !publish && start_req) |=> $stable(mux_sel_o) && busy_o)
        else $error("Start during conversion disturbed the conversion.");
    a_pace_floor: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R13]
        publish |-> (st_q.frames >= (st_q.slow ? 4'h7 : 4'h3)))
        else $error("Result published before the pacing limit.");
    a_phase_capture: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R08]
        (sclk_rise && ce_s) |=> (enc_phase_o == $past({phb_s, pha_s})))
        else $error("Phase bits not captured on serial clock rise.");
    a_report_code: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R19]
        publish |=> (reported_channel_code_o == $past(mux_sel_o) && result_o == $past(dac_code_o)))
        else $error("Reported code does not match converted source.");
    a_gain_apply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R16]
        ##1 1'b1 |-> (gain_o == $past(gain_set_i)))
        else $error("Gain not applied on the next cycle.");
    a_sample_len: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R01]
        $rose(st_q.state == adc_seq_pkg::ST_CONVERT) |-> $past(st_q.sclks) == 4'hE)
        else $error("Sampling did not last fifteen serial clocks.");
endmodule // encoder_adc_sequencer

// ---- sim/host_frame_model.sv ----
`timescale 1ns/1ps
module host_frame_model (
    input wire logic ref_clk_i, // System clock used to pace the serial link.
    output logic sclk_o,        // Serial clock, still and low outside frames.
    output logic ce_o,          // Chip enable, high for the whole frame.
    output logic mosi_o         // Serial data, msb first.
);
    // The link rests with the device deselected.
    initial begin
        sclk_o = 1'b0;
        ce_o = 1'b0;
        mosi_o = 1'b0;
    end

    // Waits whole clock cycles, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Data changes on the falling serial edge, so it is steady around each rise.
    // Only normal and config words are sent, never a diagnostic request.
    task automatic send(input logic [15:0] w);
        ce_o = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = w[i];
            tick(4);
            sclk_o = 1'b1;
            tick(4);
            sclk_o = 1'b0;
        end
        tick(4);
        ce_o = 1'b0;
        // Deselected data is not trusted, so it shows the inverse of the last bit.
        mosi_o = ~mosi_o;
        tick(16);
    endtask
endmodule // host_frame_model

// ---- sim/encoder_adc_sequencer_bench.sv ----
`timescale 1ns/1ps
module encoder_adc_sequencer_bench;
    logic ref_clk_i, sys_rst_i, comp_i, pa, pb, amp_route_i, sclk, ce, mosi;
    logic sample_hold_o, busy_o, first_done_o, second_done_o, amp_monitor_drive_o, cfg_slow_o;
    logic [adc_seq_pkg::GAIN_BITS-1:0] gain_set_i, gain_o;
    logic [2:0] mux_sel_o, reported_channel_code_o;
    logic [7:0] dac_code_o, result_o, held;
    logic [1:0] enc_phase_o;
    logic [23:0] position_o;
    logic [15:0] qexp;
    logic [1:0] ph [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [5:0] pr [4] = '{6'o45, 6'o46, 6'o57, 6'o23};
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    host_frame_model host (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .ce_o(ce), .mosi_o(mosi));

    encoder_adc_sequencer dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .ce_i(ce),
        .mosi_i(mosi), .comp_i(comp_i), .enc_phase_a_bit_i(pa), .enc_phase_b_bit_i(pb),
        .gain_set_i(gain_set_i), .amp_route_i(amp_route_i), .mux_sel_o(mux_sel_o),
        .sample_hold_o(sample_hold_o), .dac_code_o(dac_code_o), .busy_o(busy_o), .result_o(result_o),
        .first_done_o(first_done_o), .second_done_o(second_done_o),
        .reported_channel_code_o(reported_channel_code_o), .enc_phase_o(enc_phase_o),
        .position_o(position_o), .gain_o(gain_o), .amp_monitor_drive_o(amp_monitor_drive_o),
        .cfg_slow_o(cfg_slow_o));

    // Clock at 250 MHz.
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Analog front end: the hold capacitor follows the selected source while tracking.
    // The held level sits half a code above its integer, so the result equals that integer.
    always @(posedge ref_clk_i) begin
        #1;
        if (sample_hold_o === 1'b1) held = lvl(mux_sel_o);
        comp_i = (held >= dac_code_o);
    end

    // A hung handshake would stall the run, so a cycle ceiling forces the report.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end

    function automatic logic [7:0] lvl(input logic [2:0] s);
        return 8'h17 + 8'h1d * {5'h00, s};
    endfunction

    function automatic logic [15:0] start_word(input logic [2:0] f);
        return {11'h000, f, 2'b10};
    endfunction

    function automatic int gray_pos(input logic a, input logic b);
        return a ? (b ? 2 : 1) : (b ? 3 : 0);
    endfunction

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // Moves the phase pins one state and tracks the count that should follow.
    task automatic set_phase(input logic a, input logic b);
        int d;
        d = (gray_pos(a, b) - gray_pos(pa, pb) + 4) % 4;
        if (d == 1) qexp++;
        else if (d == 3) qexp--;
        @(posedge ref_clk_i);
        #1;
        pa = a;
        pb = b;
        repeat (8) @(posedge ref_clk_i);
    endtask

    // Sends idle frames until the chosen done bit shows; limit plus one means never.
    task automatic wait_done(input logic sel, input int limit, output int k);
        for (k = 1; k <= limit; k++) begin
            host.send(16'h0000);
            if ((sel ? second_done_o : first_done_o) === 1'b1) return;
        end
    endtask

    // One conversion cycle, or a pair when the field msb is set.
    task automatic conv(input logic [2:0] f, input logic [2:0] s1, input logic [2:0] s2, input int frames);
        int k;
        host.send(start_word(f));
        chk("captured phases", 24'({pb, pa}), 24'(enc_phase_o));
        chk("busy after start", 24'h00_0001, 24'(busy_o));
        wait_done(1'b0, 12, k);
        chk("frames to first", 24'(frames), 24'(k));
        chk("first code", 24'(s1), 24'(reported_channel_code_o));
        chk("first position", {qexp, lvl(s1)}, position_o);
        if (f[2]) begin
            wait_done(1'b1, 12, k);
            chk("frames to second", 24'(frames), 24'(k));
            chk("second code", 24'(s2), 24'(reported_channel_code_o));
            chk("second position", {qexp, lvl(s2)}, position_o);
        end
        host.send(16'h0000);
        chk("done one frame", 24'h00_0000, 24'({first_done_o, second_done_o, busy_o}));
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Main sequence.
    initial begin
        sys_rst_i = 1'b1;
        comp_i = 1'b0;
        held = 8'h00;
        pa = 1'b0;
        pb = 1'b0;
        qexp = 16'h0000;
        gain_set_i = 4'h0;
        amp_route_i = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        chk("outputs in reset", 24'h00_0000, 24'({busy_o, first_done_o, result_o, gain_o, cfg_slow_o}));
        #1;
        sys_rst_i = 1'b0;
        amp_route_i = 1'b1;
        gain_set_i = 4'ha;
        repeat (3) @(posedge ref_clk_i);
        chk("monitor routing", 24'h00_0001, 24'(amp_monitor_drive_o));
        chk("gain applied", 24'h00_000a, 24'(gain_o));
        for (int f = 0; f < 2; f++) conv(f[2:0], f[2:0], 3'h0, 4);
        for (int i = 0; i < 4; i++) begin
            set_phase(ph[i][1], ph[i][0]);
            conv(3'h3, 3'h4 + i[2:0], 3'h0, 4);
        end
        set_phase(1'b0, 1'b1);
        set_phase(1'b1, 1'b1);
        set_phase(1'b1, 1'b0);
        chk("count down", 24'(qexp), 24'(position_o[23:8]));
        for (int i = 0; i < 4; i++) conv(3'h4 + i[2:0], pr[i][5:3], pr[i][2:0], 4);
        host.send(start_word(3'h0));
        host.send(start_word(3'h1));
        @(posedge ref_clk_i);
        #1;
        gain_set_i = 4'h5;
        repeat (2) @(posedge ref_clk_i);
        chk("gain while busy", 24'h00_0015, 24'({busy_o, gain_o}));
        wait_done(1'b0, 12, n);
        chk("refused frames", 24'h00_0003, 24'(n));
        chk("refused code", 24'(adc_seq_pkg::SRC_GEN0), 24'(reported_channel_code_o));
        wait_done(1'b0, 5, n);
        chk("no extra result", 24'h00_0006, 24'(n));
        host.send(start_word(3'h0));
        repeat (3) host.send(16'h0000);
        host.send(start_word(3'h1));
        chk("publish with start", 24'h00_0008, 24'({first_done_o, reported_channel_code_o}));
        wait_done(1'b0, 12, n);
        chk("back to back", 24'h00_0004, 24'(n));
        chk("back to back code", 24'(adc_seq_pkg::SRC_GEN1), 24'(reported_channel_code_o));
        host.send(16'h0009);
        chk("slow config", 24'h00_0001, 24'(cfg_slow_o));
        conv(3'h1, 3'h1, 3'h0, 8);
        host.send(16'h0001);
        chk("fast config", 24'h00_0000, 24'(cfg_slow_o));
        end_of_test();
    end
endmodule // encoder_adc_sequencer_bench
